// ==== common/lds_pkg.sv ====
/*
  Shared constants and types of the serial input stage of the LED sink
  driver: shift register size, grayscale layout, latch decoding, FIFO.
  Assumes it is compiled before every design file that names it.
*/
package lds_pkg;
  localparam int SHIFT_BITS = 48;
  localparam int CHANNELS = 16;
  localparam int CH_IDX_BITS = 4;
  localparam int GS_BITS = 16;
  localparam int BLUE_LSB = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int PIN_COUNT = 4;
  // pin positions inside the synchroniser vector
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_LATCH = 2;
  localparam int PIN_GRAYSCALE_PWM_CLOCK = 3;
  // shift-clock edges seen while the latch strobe is high
  localparam logic [1:0] EDGES_FC_FIRST = 2'h2;
  localparam logic [1:0] EDGES_FC_SECOND = 2'h3;
  localparam logic [1:0] EDGES_RESET = 2'h0;
  localparam logic [47:0] SHIFT_RESET = 48'h0000_0000_0000;
  localparam logic [15:0] GS_RESET = 16'h0000;
  localparam logic [3:0] PINS_RESET = 4'h0;

  typedef enum logic [2:0] {
    LDS_TGT_GS = 3'b001,
    LDS_TGT_FC_FIRST = 3'b010,
    LDS_TGT_FC_SECOND = 3'b100
  } lds_target_e;

  typedef struct packed {
    lds_target_e target;
    logic [47:0] data;
  } lds_word_s;
endpackage : lds_pkg

// ==== design/lds_fifo.sv ====
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock and a reset already synchronised by the caller.
*/
`timescale 1ns/1ns
module lds_fifo #(
  parameter int WIDTH = 51,
  parameter int DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  // honest flags: full blocks the filler, empty hides stale data
  assign o_in_ready = (count != FULL_COUNT);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  // storage has no reset; only written slots are ever read
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lds_fifo

// ==== design/lds_top.sv ====
/*
  Serial input stage of a 48-channel LED sink driver: pin synchronisers,
  the 48-bit common shift register with daisy-chain output, latch decode
  into a FIFO, and the blue grayscale store with its PWM comparators.
  Assumes the four link pins are asynchronous to i_mclk and change slower than it; i_update_hold is used unsynchronised.
*/
`timescale 1ns/1ns
module lds_top #(
  parameter int SHIFT_BITS = lds_pkg::SHIFT_BITS,
  parameter int FIFO_DEPTH = lds_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_shift_clock,
  input wire logic i_serial_data_in,
  input wire logic i_latch_strobe,
  input wire logic i_grayscale_pwm_clock,
  input wire logic i_update_hold,
  output logic o_serial_data_out,
  output logic o_capture_ready,
  output logic [15:0] o_blue_sink_output,
  output logic [47:0] o_function_control_first,
  output logic [47:0] o_function_control_second
);
  localparam int WW = $bits(lds_pkg::lds_word_s);

  // queue entries are told apart in three places, so one compare
  function automatic logic is_target(
    input lds_pkg::lds_word_s w,
    input lds_pkg::lds_target_e t
  );
    return w.target == t;
  endfunction : is_target

  // bits high in the first vector and low in the second; gives rise
  // and fall of the settled pin levels from one expression
  function automatic logic [3:0] only_in_first(
    input logic [3:0] a,
    input logic [3:0] b
  );
    return a & ~b;
  endfunction : only_in_first

  logic rst_s1;
  logic rst_s2;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_level;
  logic [SHIFT_BITS-1:0] shift_reg;
  logic [1:0] latch_edges;
  logic [15:0] gs_mem [lds_pkg::CHANNELS];
  logic [3:0] gs_idx;
  logic [15:0] pwm_cnt;
  logic [15:0] next_sink;
  lds_pkg::lds_word_s push_word;
  lds_pkg::lds_word_s pop_word;
  logic fifo_in_ready;
  logic fifo_out_valid;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire nrst = rst_s2;

  // raw pin vector, one bit per pin position of the package
  wire [3:0] pin_raw = {i_grayscale_pwm_clock, i_latch_strobe,
                        i_serial_data_in, i_shift_clock};

  // a level counts only once stages two and three agree, which
  // rejects a single-sample glitch on every pin but serial data, which is taken from stage three
  wire [3:0] agree = ~(pin_s2 ^ pin_s3);
  wire [3:0] next_level = (agree & pin_s2) | (~agree & pin_level);
  wire [3:0] pin_rise = only_in_first(next_level, pin_level);
  wire [3:0] pin_fall = only_in_first(pin_level, next_level);
  wire sclk_rise = pin_rise[lds_pkg::PIN_SCLK];
  wire latch_fall = pin_fall[lds_pkg::PIN_LATCH];
  wire latch_high = pin_level[lds_pkg::PIN_LATCH];
  wire grayscale_pwm_clock_rise = pin_rise[lds_pkg::PIN_GRAYSCALE_PWM_CLOCK];
  // data and clock share the same delay, so the stage-three data sample
  // lines up with the clock edge the controller meant
  wire sdata = pin_s3[lds_pkg::PIN_SDATA];

  // three-flop synchronisers; stage one feeds stage two only
  always_ff @(posedge i_mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= lds_pkg::PINS_RESET;
      pin_s2 <= lds_pkg::PINS_RESET;
      pin_s3 <= lds_pkg::PINS_RESET;
      pin_level <= lds_pkg::PINS_RESET;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_level <= next_level;
    end
  end

  // common shift register: shift up, new bit at the bottom
  always_ff @(posedge i_mclk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= lds_pkg::SHIFT_RESET;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[SHIFT_BITS-2:0], sdata};
    end
  end

  // chain output is the MSB itself, already a flop
  assign o_serial_data_out = shift_reg[SHIFT_BITS-1];

  // count shift-clock rises while the latch is high; saturates
  always_ff @(posedge i_mclk or negedge nrst) begin
    if (!nrst) begin
      latch_edges <= lds_pkg::EDGES_RESET;
    end else if (!latch_high) begin
      latch_edges <= lds_pkg::EDGES_RESET;
    end else if (sclk_rise && latch_edges != lds_pkg::EDGES_FC_SECOND) begin
      latch_edges <= latch_edges + 2'h1;
    end
  end

  // latch decode: the pulse width in shift edges picks the target
  wire sel_fc2 = (latch_edges >= lds_pkg::EDGES_FC_SECOND);
  wire sel_fc1 = (latch_edges == lds_pkg::EDGES_FC_FIRST);
  assign push_word.target = sel_fc2 ? lds_pkg::LDS_TGT_FC_SECOND :
                            sel_fc1 ? lds_pkg::LDS_TGT_FC_FIRST :
                            lds_pkg::LDS_TGT_GS;
  assign push_word.data = shift_reg;
  // a latch while the FIFO is full is dropped; ready warns the controller
  assign o_capture_ready = fifo_in_ready;

  // the hold input stalls updates so a frame can be loaded whole
  wire drain = fifo_out_valid && !i_update_hold;
  wire wr_gs = drain && is_target(pop_word, lds_pkg::LDS_TGT_GS);
  wire wr_fc1 = drain && is_target(pop_word, lds_pkg::LDS_TGT_FC_FIRST);
  wire wr_fc2 = drain && is_target(pop_word, lds_pkg::LDS_TGT_FC_SECOND);
  wire [15:0] blue_word = pop_word.data[lds_pkg::BLUE_LSB +: 16];

  // decoupling queue: a held drain lets a frame of latches pile up
  lds_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_nrst(nrst),
    .i_in_valid(latch_fall),
    .o_in_ready(fifo_in_ready),
    .i_in_data(push_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(drain),
    .o_out_data(pop_word)
  );

  // function control words
  always_ff @(posedge i_mclk or negedge nrst) begin
    if (!nrst) begin
      o_function_control_first <= lds_pkg::SHIFT_RESET;
      o_function_control_second <= lds_pkg::SHIFT_RESET;
    end else begin
      if (wr_fc1) begin
        o_function_control_first <= pop_word.data;
      end
      if (wr_fc2) begin
        o_function_control_second <= pop_word.data;
      end
    end
  end

  // grayscale words fill the blue channels in turn, index wraps
  always_ff @(posedge i_mclk or negedge nrst) begin
    if (!nrst) begin
      gs_idx <= '0;
      for (int i = 0; i < lds_pkg::CHANNELS; i++) begin
        gs_mem[i] <= lds_pkg::GS_RESET;
      end
    end else if (wr_gs) begin
      gs_mem[gs_idx] <= blue_word;
      gs_idx <= gs_idx + 4'h1;
    end
  end

  // pwm counter advances per grayscale clock rise; it freezes when the
  // clock stops, so outputs then change only when a grayscale word is written
  always_ff @(posedge i_mclk or negedge nrst) begin
    if (!nrst) begin
      pwm_cnt <= lds_pkg::GS_RESET;
    end else if (grayscale_pwm_clock_rise) begin
      pwm_cnt <= pwm_cnt + 16'h0001;
    end
  end

  // channel sinks while the count is below its grayscale value
  always_comb begin
    next_sink = '0;
    for (int i = 0; i < lds_pkg::CHANNELS; i++) begin
      next_sink[i] = (pwm_cnt < gs_mem[i]);
    end
  end

  // sinks come from a flop so the pins never see compare glitches
  always_ff @(posedge i_mclk or negedge nrst) begin
    if (!nrst) begin
      o_blue_sink_output <= '0;
    end else begin
      o_blue_sink_output <= next_sink;
    end
  end
endmodule : lds_top

// ==== test/lds_checker_sva.sv ====
/*
  Port checker of the serial input stage: shift, chain output, latch.
  Assumes the pins change well apart, as the bench's controller does.
*/
`timescale 1ns/1ns
module lds_checker (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_shift_clock,
  input wire logic i_latch_strobe,
  input wire logic i_grayscale_pwm_clock,
  input wire logic o_serial_data_out,
  input wire logic o_capture_ready,
  input wire logic [15:0] o_blue_sink_output,
  input wire logic [47:0] o_function_control_first,
  input wire logic [47:0] o_function_control_second
);
  logic [7:0] age_s, age_l, age_g;
  logic [2:0] pin_q;
  wire rise_s = i_shift_clock & ~pin_q[0];
  wire fall_l = ~i_latch_strobe & pin_q[1];
  wire rise_g = i_grayscale_pwm_clock & ~pin_q[2];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // cycles since each pin edge; saturates so a stale edge never wraps back into a window
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_q <= 3'h0;
      age_s <= 8'hff;
      age_l <= 8'hff;
      age_g <= 8'hff;
    end else begin
      pin_q <= {i_grayscale_pwm_clock, i_latch_strobe, i_shift_clock};
      age_s <= rise_s ? 8'h00 : age_s + {7'h00, age_s != 8'hff};
      age_l <= fall_l ? 8'h00 : age_l + {7'h00, age_l != 8'hff};
      age_g <= rise_g ? 8'h00 : age_g + {7'h00, age_g != 8'hff};
    end
  end
  a_serial_data_out_after_shift: assert property ($changed(o_serial_data_out) |->
    age_s inside {[1:6]}) else $error("chain output moved without shift");
  a_serial_data_out_not_early: assert property ($rose(i_shift_clock) |=>
    $stable(o_serial_data_out)) else $error("chain output moved too early");
  a_first_by_latch: assert property ($changed(o_function_control_first) |->
    !i_latch_strobe && age_l >= 8'h02) else $error("first word early");
  a_second_by_latch: assert property ($changed(o_function_control_second)
    |-> !i_latch_strobe && age_l >= 8'h02) else $error("second word early");
  a_ready_by_push: assert property ($fell(o_capture_ready) |->
    age_l inside {[1:8]}) else $error("ready fell without a latch");
  a_blue_by_cause: assert property ($changed(o_blue_sink_output) |->
    age_g inside {[1:8]} || age_l >= 8'h02) else $error("blue moved alone");
  cover property ($fell(o_capture_ready));
  cover property ($changed(o_function_control_second));
  cover property ($rose(o_blue_sink_output[0]));
endmodule : lds_checker
bind lds_top lds_checker lds_checker_inst (.i_mclk, .i_nrst, .i_shift_clock,
  .i_latch_strobe, .i_grayscale_pwm_clock, .o_serial_data_out,
  .o_capture_ready, .o_blue_sink_output, .o_function_control_first,
  .o_function_control_second);

// ==== test/lds_ctrl_model.sv ====
/*
  Display controller model: shift clock, serial data, latch, PWM clock.
  Assumes its tasks are called one at a time from the bench.
*/
`timescale 1ns/1ns
module lds_ctrl_model (
  output logic o_shift_clock,
  output logic o_serial_data,
  output logic o_latch_strobe,
  output logic o_gs_clock
);
  // all pins idle low; the shift clock stands still between frames
  initial begin
    o_shift_clock = 1'h0;
    o_serial_data = 1'h0;
    o_latch_strobe = 1'h0;
    o_gs_clock = 1'h0;
  end
  // 125 ns bit; data held 30 ns past the rise, then flipped so a late
  // sample shows; started 1 ns after an mclk edge, no pin moves on one
  task automatic send_bit(input logic b);
    o_serial_data = b;
    #62 o_shift_clock = 1'h1;
    #30 o_serial_data = ~b;
    #33 o_shift_clock = 1'h0;
  endtask : send_bit
  task automatic pulse_latch();
    #40 o_latch_strobe = 1'h1;
    #60 o_latch_strobe = 1'h0;
    #200;
  endtask : pulse_latch
  // latch goes high before the last n_hi rises to pick the target
  task automatic send_word(input logic [47:0] w, input int n_hi);
    for (int i = 47; i >= 0; i--) begin
      if (i == n_hi - 1) o_latch_strobe = 1'h1;
      send_bit(w[i]);
    end
    pulse_latch();
  endtask : send_word
  task automatic gs_pulses(input int n);
    repeat (n) begin
      #40 o_gs_clock = 1'h1;
      #40 o_gs_clock = 1'h0;
    end
    #100;
  endtask : gs_pulses
endmodule : lds_ctrl_model

// ==== test/tb_top.sv ====
/*
  Self-checking bench of the serial input stage.
  Assumes the controller model owns all four pins of the link.
*/
`timescale 1ns/1ns
module tb_top;
  logic i_mclk = 1'h0;
  logic i_nrst = 1'h0;
  logic i_update_hold = 1'h0;
  logic sclk, sdata, lat, grayscale_pwm_clock, serial_data_out, ready;
  logic [15:0] blue;
  logic [47:0] fc1, fc2;
  int err_total = 0;
  int comparisons = 0;
  always #5 i_mclk = ~i_mclk;
  lds_top lds_top_inst (.i_mclk, .i_nrst, .i_shift_clock(sclk),
    .i_serial_data_in(sdata), .i_latch_strobe(lat),
    .i_grayscale_pwm_clock(grayscale_pwm_clock), .i_update_hold,
    .o_serial_data_out(serial_data_out), .o_capture_ready(ready),
    .o_blue_sink_output(blue), .o_function_control_first(fc1),
    .o_function_control_second(fc2));
  lds_ctrl_model lds_ctrl_model_inst (.o_shift_clock(sclk),
    .o_serial_data(sdata), .o_latch_strobe(lat), .o_gs_clock(grayscale_pwm_clock));
  task automatic check(input string nm, input logic [47:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // channel 0 gets 3: on while the pwm count is below 3, off after
  task automatic scen_gs();
    lds_ctrl_model_inst.send_word(48'h0003_0000_0000, 0);
    check("blue at count 0", 48'h1, 48'(blue));
    lds_ctrl_model_inst.gs_pulses(3);
    check("blue at count 3", 48'h0, 48'(blue));
  endtask : scen_gs
  // a word goes in, then zeros push it out msb first on the chain pin
  task automatic scen_shift();
    logic [47:0] pat = 48'ha5c3_0f1e_7b2b;
    logic [47:0] seen;
    for (int i = 47; i >= 0; i--) lds_ctrl_model_inst.send_bit(pat[i]);
    for (int i = 47; i >= 0; i--) begin
      seen[i] = serial_data_out;
      lds_ctrl_model_inst.send_bit(1'h0);
    end
    check("chain word", pat, seen);
  endtask : scen_shift
  // two rises under the latch pick the first word, three the second
  task automatic scen_fc();
    lds_ctrl_model_inst.send_word(48'h1234_5678_9abc, 2);
    check("first word", 48'h1234_5678_9abc, fc1);
    check("second untouched", 48'h0, fc2);
    lds_ctrl_model_inst.send_word(48'hfedc_ba98_7654, 3);
    check("second word", 48'hfedc_ba98_7654, fc2);
  endtask : scen_fc
  // stall the drain, fill the queue until it refuses, then drain it
  task automatic scen_fifo();
    int n = 0;
    @(posedge i_mclk) #1 i_update_hold = 1'h1;
    while (ready === 1'h1 && n < 40) begin
      lds_ctrl_model_inst.pulse_latch();
      n++;
    end
    check("queued words", 48'(lds_pkg::FIFO_DEPTH), 48'(n));
    @(posedge i_mclk) #1 i_update_hold = 1'h0;
    for (int k = 0; k < 100 && ready !== 1'h1; k++) @(posedge i_mclk);
    check("ready after drain", 48'h1, 48'(ready));
  endtask : scen_fifo
  initial begin
    repeat (8) @(posedge i_mclk);
    #1 i_nrst = 1'h1;
    repeat (8) @(posedge i_mclk);
    #1;
    scen_gs();
    scen_shift();
    scen_fc();
    scen_fifo();
    complete_run();
  end
endmodule : tb_top
